// ==== rtl/occ_regs.vh ====
// Constants of the output clock sync and coding block.
// Included by the coder, the top and the bench; definitions only.
`ifndef OCC_REGS_VH
`define OCC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OCC_ADDR_CTRL 8'h00
`define OCC_ADDR_SPAN 8'h04
`define OCC_ADDR_OFFS 8'h08
`define OCC_ADDR_STATE 8'h0C
`define OCC_ADDR_STAT 8'h10
`define OCC_ADDR_MASK 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCC_CTRL_EXT 0
`define OCC_CTRL_EDGE 1
`define OCC_CTRL_DDR 2
`define OCC_OFFS_SIGN 8
`define OCC_EV_REALIGNED 0
`define OCC_EV_OOR 1
`define OCC_EV_CALHIT 2
`define OCC_EV_W 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OCC_CTRL_RST 3'h0
`define OCC_SPAN_RST 10'h2BC
`define OCC_OFFS_RST 9'h000
`define OCC_MASK_RST 3'h0

// ----------------------------------------------------------------
// Coding: fixed spans in half-millivolt units, extended limits in mV
// ----------------------------------------------------------------
`define OCC_SPAN_HIGH 11'h6CC
`define OCC_SPAN_LOW 11'h519
`define OCC_EXT_MIN_MV 10'h230
`define OCC_EXT_MAX_MV 10'h348
`define OCC_MID_CODE 40'sd128
`define OCC_CODE_MAX 40'sd255
`define OCC_CODE_ZERO 8'h00
`define OCC_CODE_FULL 8'hFF
`define OCC_SCALE_MILLI 40'sd1000
`define OCC_OFFS_STEP 40'sd352
`define OCC_NZ_NUM 40'sd25
`define OCC_NZ_DEN 40'sd64

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OCC_CLK_MHZ 200
`define OCC_TAD_NS 10
`define OCC_TAD_CYC ((`OCC_TAD_NS * `OCC_CLK_MHZ + 999) / 1000)

`endif

// ==== rtl/occ_sync.v ====
// Two flip-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that stays put for several clk periods.
`timescale 1ns/100ps
module occ_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Levels
    input wire [W-1:0] async,
    output reg [W-1:0] sync
);

reg [W-1:0] meta;

// First stage feeds only the second stage
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        meta <= {W{1'b0}};
        sync <= {W{1'b0}};
    end else begin
        meta <= async;
        sync <= meta;
    end
end

endmodule // occ_sync

// ==== rtl/occ_coder.v ====
// Offset binary coder: differential input to 8-bit code.
// Assumes a signed input in half-millivolt units and a span likewise.
`timescale 1ns/100ps
`include "occ_regs.vh"
module occ_coder (
    // Sample and settings
    input wire signed [11:0] analogIn,
    input wire [10:0] spanHalfMv,
    input wire offsetNeg,
    input wire [7:0] offsetMag,
    // Result
    output reg [7:0] code,
    output reg outOfRange
);

reg signed [39:0] vx;
reg signed [39:0] num;
reg signed [39:0] den;
reg signed [39:0] offs;
reg signed [39:0] nz;
reg signed [39:0] q;
reg signed [39:0] idx;

always @* begin
    vx = {{28{analogIn[11]}}, analogIn};
    offs = $signed({32'h0, offsetMag}) * `OCC_OFFS_STEP;
    // A tenth of an LSB, in the same units as num
    nz = $signed({29'h0, spanHalfMv}) * `OCC_NZ_NUM / `OCC_NZ_DEN;
    num = vx * `OCC_SCALE_MILLI;
    if (offsetNeg) begin
        num = num - offs - nz;
    end else begin
        num = num + offs;
    end
    num = num <<< 8;
    den = $signed({29'h0, spanHalfMv}) * `OCC_SCALE_MILLI;
    // Floor division, so zero input splits between 127 and 128
    if (num < 0) begin
        q = (num - den + 40'sd1) / den;
    end else begin
        q = num / den;
    end
    idx = q + `OCC_MID_CODE;
    if (idx < 0) begin
        code = `OCC_CODE_ZERO;
        outOfRange = 1'b1;
    end else if (idx > `OCC_CODE_MAX) begin
        code = `OCC_CODE_FULL;
        outOfRange = 1'b1;
    end else begin
        code = idx[7:0];
        outOfRange = 1'b0;
    end
end

endmodule // occ_coder

// ==== rtl/occ_top.v ====
// Output clock realignment and output coding of a sampling converter.
// Assumes the sample clock and all pins are asynchronous to clk, with
// the sample clock slow enough that clk sees each of its levels.
`timescale 1ns/100ps
`include "occ_regs.vh"

// Behaviour
// - Realign request is accepted at any time, unaligned to sample clock.
// - While realign is held, strobe stays at a level set by rate and edge.
// - Asserting realign may cut the strobe into one short pulse.
// - After release, next sample falling edge fixes the strobe phase.
// - Strobe restarts after the normal input-to-output delay.
// - Codes are 8 bits and saturate at all zeros or all ones.
// - Out-of-range flag is high exactly while the sample is out of range.
// - Offset binary: zero sits between 127 and 128; halves at 64, 192.
// - Pin mode: select high is the large range, low is 75 percent.
// - Extended mode accepts a range from 560 mV to 840 mV.
// - Offset plus zero and minus zero differ by a tenth of an LSB.
// - SDR: edge select 1 changes data on strobe rise, 0 on fall.
module occ_top (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port
    input wire [7:0] addr,
    input wire [31:0] wrData,
    input wire wrEn,
    input wire rdEn,
    output reg [31:0] rdData,
    // Sample clock and control pins
    input wire sampleClk,
    input wire outputClockRealign,
    input wire fullScaleSelect,
    input wire outputEdgePin,
    input wire ddrModePin,
    input wire calibrationInProgress,
    // Analog sample, half-millivolt units
    input wire [11:0] analogIn,
    // Outputs to the capturing logic
    output reg outputDataStrobe,
    output reg [7:0] dataOut,
    output reg outOfRange,
    // Interrupt
    output reg irq
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam ST_RUN = 4'b0001;
localparam ST_HOLD = 4'b0010;
localparam ST_ARM = 4'b0100;
localparam ST_PHASE = 4'b1000;

localparam integer TAD_FULL = `OCC_TAD_CYC;
localparam [3:0] TAD_CYC = TAD_FULL[3:0];

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
wire [5:0] pinSync;
wire [11:0] analogSync;
wire sclkS;
wire realignS;
wire fsrS;
wire edgeS;
wire ddrS;
wire calS;
reg sclkPrev;
wire sclkRise;
wire sclkFall;
reg [2:0] ctrl;
reg [9:0] spanMv;
reg [8:0] offs;
reg [2:0] stat;
reg [2:0] mask;
reg [3:0] state;
reg [3:0] next_state;
reg [3:0] dly;
reg [7:0] pendCode;
reg pendOor;
reg [2:0] next_stat;
reg [2:0] events;
reg [10:0] span;
reg [9:0] spanClamp;
wire useExt;
wire edgeSel;
wire ddrSel;
wire holdLevel;
wire [7:0] coded;
wire codedOor;
wire fire;
wire next_strobe;
wire dataStep;
wire statRead;

// ----------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------
// Realign is caught asynchronously to the sample clock
occ_sync #(.W(6)) uPins (
    .clk(clk),
    .rst_b(rst_b),
    .async({calibrationInProgress, ddrModePin, outputEdgePin,
            fullScaleSelect, outputClockRealign, sampleClk}),
    .sync(pinSync)
);

// Sample is taken a sample-clock edge after it settled, so the
// multi-bit crossing sees a stable word
occ_sync #(.W(12)) uSample (
    .clk(clk),
    .rst_b(rst_b),
    .async(analogIn),
    .sync(analogSync)
);

assign sclkS = pinSync[0];
assign realignS = pinSync[1];
assign fsrS = pinSync[2];
assign edgeS = pinSync[3];
assign ddrS = pinSync[4];
assign calS = pinSync[5];

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        sclkPrev <= 1'b0;
    end else begin
        sclkPrev <= sclkS;
    end
end

assign sclkRise = sclkS & ~sclkPrev;
assign sclkFall = ~sclkS & sclkPrev;

// ----------------------------------------------------------------
// Mode selection
// ----------------------------------------------------------------
assign useExt = ctrl[`OCC_CTRL_EXT];
assign edgeSel = useExt ? ctrl[`OCC_CTRL_EDGE] : edgeS;
assign ddrSel = useExt ? ctrl[`OCC_CTRL_DDR] : ddrS;
// Held level puts the first restart edge on a data change
assign holdLevel = ~ddrSel & ~edgeSel;

always @* begin
    spanClamp = spanMv;
    if (spanMv < `OCC_EXT_MIN_MV) begin
        spanClamp = `OCC_EXT_MIN_MV;
    end else if (spanMv > `OCC_EXT_MAX_MV) begin
        spanClamp = `OCC_EXT_MAX_MV;
    end
    if (useExt) begin
        span = {spanClamp, 1'b0};
    end else if (fsrS) begin
        span = `OCC_SPAN_HIGH;
    end else begin
        span = `OCC_SPAN_LOW;
    end
end

// ----------------------------------------------------------------
// Coder
// ----------------------------------------------------------------
occ_coder uCoder (
    .analogIn(analogSync),
    .spanHalfMv(span),
    .offsetNeg(offs[`OCC_OFFS_SIGN]),
    .offsetMag(offs[7:0]),
    .code(coded),
    .outOfRange(codedOor)
);

// ----------------------------------------------------------------
// Realign sequencer
// ----------------------------------------------------------------
always @* begin
    next_state = state;
    case (state)
        ST_RUN: begin
            if (realignS) begin
                next_state = ST_HOLD;
            end
        end
        ST_HOLD: begin
            if (!realignS) begin
                next_state = ST_ARM;
            end
        end
        ST_ARM: begin
            // Release lines up with a sample rising edge
            if (realignS) begin
                next_state = ST_HOLD;
            end else if (sclkS) begin
                // Clock already high, so the coming fall is the next one
                next_state = ST_PHASE;
            end
        end
        ST_PHASE: begin
            if (realignS) begin
                next_state = ST_HOLD;
            end else if (sclkFall) begin
                next_state = ST_RUN;
            end
        end
        default: begin
            next_state = ST_HOLD;
        end
    endcase
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        state <= ST_RUN;
    end else begin
        state <= next_state;
    end
end

// ----------------------------------------------------------------
// Output strobe and data
// ----------------------------------------------------------------
// Same delay from a falling edge in normal running and on restart
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        dly <= 4'h0;
    end else if (next_state == ST_HOLD) begin
        dly <= 4'h0;
    end else if (sclkFall && (state == ST_RUN || state == ST_PHASE)) begin
        dly <= TAD_CYC;
    end else if (dly != 4'h0) begin
        dly <= dly - 4'h1;
    end
end

assign fire = (dly == 4'h1) && (state == ST_RUN);
assign next_strobe = ~outputDataStrobe;
assign dataStep = fire & (ddrSel | (next_strobe == edgeSel));

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        outputDataStrobe <= 1'b0;
    end else if (next_state == ST_HOLD) begin
        // May cut a strobe phase short on entry
        outputDataStrobe <= holdLevel;
    end else if (fire) begin
        outputDataStrobe <= next_strobe;
    end
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        pendCode <= `OCC_CODE_ZERO;
        pendOor <= 1'b0;
        dataOut <= `OCC_CODE_ZERO;
        outOfRange <= 1'b0;
    end else begin
        if (sclkRise) begin
            pendCode <= coded;
            pendOor <= codedOor;
        end
        if (dataStep) begin
            dataOut <= pendCode;
            outOfRange <= pendOor;
        end
    end
end

// ----------------------------------------------------------------
// Events and interrupt
// ----------------------------------------------------------------
assign statRead = rdEn && (addr == `OCC_ADDR_STAT);

always @* begin
    events = 3'h0;
    events[`OCC_EV_REALIGNED] = (state == ST_PHASE) && (next_state == ST_RUN);
    events[`OCC_EV_OOR] = sclkRise & codedOor;
    // Realign during calibration is the controller's fault
    events[`OCC_EV_CALHIT] = realignS & calS & (state == ST_RUN);
    // A new event in the clearing read still lands
    next_stat = (statRead ? 3'h0 : stat) | events;
end

always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        stat <= 3'h0;
        irq <= 1'b0;
    end else begin
        stat <= next_stat;
        irq <= |(next_stat & mask);
    end
end

// ----------------------------------------------------------------
// Register port
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl <= `OCC_CTRL_RST;
        spanMv <= `OCC_SPAN_RST;
        offs <= `OCC_OFFS_RST;
        mask <= `OCC_MASK_RST;
    end else if (wrEn) begin
        case (addr)
            `OCC_ADDR_CTRL: ctrl <= wrData[2:0];
            `OCC_ADDR_SPAN: spanMv <= wrData[9:0];
            `OCC_ADDR_OFFS: offs <= wrData[8:0];
            `OCC_ADDR_MASK: mask <= wrData[2:0];
            default: begin
            end
        endcase
    end
end

// Read data stand only in the cycle after the strobe
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        rdData <= 32'h0;
    end else if (rdEn) begin
        case (addr)
            `OCC_ADDR_CTRL: rdData <= {29'h0, ctrl};
            `OCC_ADDR_SPAN: rdData <= {22'h0, spanMv};
            `OCC_ADDR_OFFS: rdData <= {23'h0, offs};
            `OCC_ADDR_STATE: rdData <= {16'h0, dataOut, state,
                                        1'b0, ddrSel, outOfRange,
                                        outputDataStrobe};
            `OCC_ADDR_STAT: rdData <= {29'h0, stat};
            `OCC_ADDR_MASK: rdData <= {29'h0, mask};
            default: rdData <= 32'h0;
        endcase
    end else begin
        rdData <= 32'h0;
    end
end

endmodule // occ_top

// ==== test/occ_top_assertions.sv ====
// Checker of the output clock block, bound to occ_top.
// Assumes mode pins stay put while a realign is held.
`timescale 1ns/100ps
module occ_top_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic rdEn,
    input wire logic [31:0] rdData,
    input wire logic outputClockRealign,
    input wire logic outputEdgePin,
    input wire logic ddrModePin,
    input wire logic outputDataStrobe,
    input wire logic [7:0] dataOut,
    input wire logic outOfRange,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----
    // Mode pins quiet long enough to have crossed the synchronisers
    // ----
    logic [2:0] calm;
    logic [1:0] modePrev;
    wire hold = !ddrModePin && !outputEdgePin;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calm <= 3'h0;
            modePrev <= 2'h0;
        end else begin
            modePrev <= {ddrModePin, outputEdgePin};
            if (modePrev != {ddrModePin, outputEdgePin}) calm <= 3'h0;
            else if (calm != 3'h7) calm <= calm + 3'h1;
        end
    end
    hold_level_a: assert property (
        outputClockRealign[*5] ##0 calm == 3'h7 |-> outputDataStrobe == hold)
        else $error("strobe not at hold level");
    cut_bound_a: assert property (
        $rose(outputClockRealign) && calm == 3'h7
        |-> ##[1:4] outputDataStrobe == hold) else $error("realign ignored");
    restart_quiet_a: assert property (
        $fell(outputClockRealign) |-> $stable(outputDataStrobe)[*8])
        else $error("strobe restarted early");
    restart_bound_a: assert property (
        $fell(outputClockRealign) |-> ##[1:40] $changed(outputDataStrobe))
        else $error("strobe did not restart");
    sat_flag_a: assert property (
        outOfRange |-> dataOut == 8'h00 || dataOut == 8'hFF)
        else $error("flag without saturated code");
    sdr_edge_a: assert property (
        !ddrModePin && calm == 3'h7 && !outputClockRealign && $changed(dataOut)
        |-> outputDataStrobe == outputEdgePin && $changed(outputDataStrobe))
        else $error("data changed on wrong strobe edge");
    ddr_edge_a: assert property (
        ddrModePin && calm == 3'h7 && $changed(dataOut)
        |-> $changed(outputDataStrobe)) else $error("data without strobe");
    read_idle_a: assert property (!$past(rdEn) |-> rdData == 32'h0)
        else $error("read data outside its cycle");
    cover property ($fell(outputClockRealign));
    cover property ($rose(outOfRange));
    cover property ($rose(irq));
endmodule // occ_top_chk

bind occ_top occ_top_chk u_occ_top_chk (.*);

// ==== test/occ_rx_model.sv ====
// Far side: shared sample clock, realign source and data capture.
// Assumes req is held for several sample periods.
`timescale 1ns/100ps
module occ_rx_model (
    // From the bench
    input wire logic req,
    // From the block
    input wire logic outputDataStrobe,
    input wire logic [7:0] dataOut,
    // To the block; the captured word to the bench
    output logic sampleClk,
    output logic outputClockRealign,
    output logic [7:0] word
);
    initial sampleClk = 1'b0;
    initial outputClockRealign = 1'b0;
    initial word = 8'h00;
    always #24 sampleClk = ~sampleClk;
    // Set on a clock fall, released on a rise of the shared clock
    always @(sampleClk)
        if (sampleClk ^ req) outputClockRealign <= req;
    // Capture once the strobe edge has settled
    always @(outputDataStrobe) #1 word = dataOut;
endmodule // occ_rx_model

// ==== test/testbench.sv ====
// Self-checking bench of occ_top with the far-side model.
// Assumes the register map and timing of the block's constants.
`timescale 1ns/100ps
`include "occ_regs.vh"
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic fullScaleSelect = 1'b1;
    logic outputEdgePin = 1'b1;
    logic ddrModePin = 1'b0;
    logic calibrationInProgress = 1'b0;
    logic [11:0] analogIn = 12'h000;
    logic req = 1'b0;
    wire [31:0] rdData;
    wire [7:0] dataOut;
    wire [7:0] word;
    wire outputDataStrobe, outOfRange, irq, sampleClk, outputClockRealign;
    int errorCnt = 0;
    int nTests = 0;
    int vh[8] = '{-2000, -870, -435, -1, 0, 435, 869, 1000};
    int vl[4] = '{-700, -326, 326, 700};
    int sw[3] = '{600, 900, 500};
    int sp[3] = '{1200, 1680, 1120};
    int sv[3] = '{300, 420, -280};
    always #2.5 clk = ~clk;
    occ_top u_occ_top (.*);
    occ_rx_model u_occ_rx_model (.*);
    // ----
    // Access and compare tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        // Data launched at the strobe edge are read at the end of their cycle
        @(posedge clk);
        check(rdData & m, e);
    endtask
    // Flag in bit 8; floor division, also below zero
    function automatic logic [8:0] expc(int v, int span, bit negz);
        int n, q;
        n = v * 2560 - (negz ? span : 0);
        q = n / (span * 10);
        if (n % (span * 10) != 0 && n < 0) q--;
        q += 128;
        if (q < 0) return 9'h100;
        if (q > 255) return 9'h1FF;
        return {1'b0, q[7:0]};
    endfunction
    task automatic samp(input int v, input int span, input bit negz);
        logic [8:0] e;
        analogIn <= v[11:0];
        repeat (40) @(posedge clk);
        e = expc(v, span, negz);
        check({23'h0, outOfRange, dataOut}, {23'h0, e});
        check({24'h0, word}, {24'h0, e[7:0]});
    endtask
    task automatic finalReport;
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        int k;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(`OCC_ADDR_STATE, 32'hFF, 32'h10);
        rd(`OCC_ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(`OCC_ADDR_SPAN, 32'hFFFFFFFF, 32'h2BC);
        rd(`OCC_ADDR_OFFS, 32'hFFFFFFFF, 32'h0);
        rd(`OCC_ADDR_MASK, 32'hFFFFFFFF, 32'h0);
        wr(8'h18, 32'h5);
        rd(8'h18, 32'hFFFFFFFF, 32'h0);
        foreach (vh[i])
            samp(vh[i], 1740, 1'b0);
        fullScaleSelect <= 1'b0;
        foreach (vl[i]) samp(vl[i], 1305, 1'b0);
        // Extended mode with the same edge and rate as the pins
        wr(`OCC_ADDR_CTRL, 32'h3);
        foreach (sw[i]) begin
            wr(`OCC_ADDR_SPAN, sw[i]);
            samp(sv[i], sp[i], 1'b0);
        end
        wr(`OCC_ADDR_SPAN, 32'h2BC);
        samp(0, 1400, 1'b0);
        wr(`OCC_ADDR_OFFS, 32'h100);
        samp(0, 1400, 1'b1);
        // Masked event keeps the interrupt low
        analogIn <= 12'h7D0;
        repeat (40) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(`OCC_ADDR_MASK, 32'h2);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(`OCC_ADDR_STAT, 32'h2, 32'h2);
        analogIn <= 12'h000;
        repeat (40) @(posedge clk);
        rd(`OCC_ADDR_STAT, 32'h5, 32'h0);
        rd(`OCC_ADDR_STAT, 32'h2, 32'h0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        // Back to pin control for the realign scenarios
        wr(`OCC_ADDR_CTRL, 32'h0);
        for (int m = 0; m < 4; m++) begin
            {ddrModePin, outputEdgePin} <= m[1:0];
            repeat (20) @(posedge clk);
            req <= 1'b1;
            repeat (30) @(posedge clk);
            check({31'h0, outputDataStrobe},
                  {31'h0, ~m[1] & ~m[0]});
            rd(`OCC_ADDR_STAT, 32'h1, 32'h0);
            req <= 1'b0;
            k = 0;
            while (outputDataStrobe === (~m[1] & ~m[0]) && k < 60) begin
                @(posedge clk);
                k++;
            end
            check({31'h0, outputDataStrobe}, {31'h0, m[1] | m[0]});
            rd(`OCC_ADDR_STAT, 32'h1, 32'h1);
        end
        // Realign while calibrating still realigns and is also flagged
        calibrationInProgress <= 1'b1;
        req <= 1'b1;
        repeat (30) @(posedge clk);
        req <= 1'b0;
        repeat (40) @(posedge clk);
        calibrationInProgress <= 1'b0;
        rd(`OCC_ADDR_STAT, 32'h4, 32'h4);
        finalReport;
    end
    initial begin
        #100000;
        errorCnt++;
        finalReport;
    end
endmodule // testbench
